// [bench/ext_clock_source.sv]
// External clock source on the channel zero pin
`timescale 1ns/1ns
module ext_clock_source (
    input wire logic CLK,
    input wire logic run,
    input wire logic [3:0] half,
    output logic pin
);
    logic [3:0] cnt;
    // Still and low between bursts; half of 2 or more keeps a quarter of CLK at most
    always_ff @(posedge CLK) begin
        if (!run) begin
            cnt <= 4'h0;
            pin <= 1'b0;
        end else if (cnt >= half - 4'h1) begin
            cnt <= 4'h0;
            pin <= ~pin;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// [bench/timer_pwm_counter_core_sva.sv]
// Bus handshake and pin ownership checks for the timer counter core
`timescale 1ns/1ns
module timer_pwm_counter_core_sva #(
    parameter int NCH = 2
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [timer_pwm_pkg::ADR_W-1:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [timer_pwm_pkg::DAT_W-1:0] DAT_I,
    input wire logic [timer_pwm_pkg::DAT_W-1:0] DAT_O,
    input wire logic ACK_O,
    input wire logic [NCH-1:0] CH_OE,
    input wire logic [NCH-1:0] CH_PIN_OWN,
    input wire logic [NCH-1:0] CH_PULLUP,
    input wire logic [NCH-1:0] CH_IRQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    logic ext;
    // Follows the clock source field as seen at the bus
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ext <= 1'b0;
        end else if (ACK_O && WE_I && SEL_I[0] && ADR_I == timer_pwm_pkg::A_STATUS_CTRL) begin
            ext <= DAT_I[4:3] == 2'b11;
        end
    end
    sequence s_req;
        CYC_I && STB_I && !ACK_O;
    endsequence
    // Two samples allow for the output register stage
    sequence s_ext;
        ext ##1 ext;
    endsequence
    property p_ack_next;
        s_req |=> ACK_O;
    endproperty
    property p_ack_pulse;
        ACK_O |=> !ACK_O;
    endproperty
    property p_ack_cause;
        ACK_O |-> $past(CYC_I) && $past(STB_I);
    endproperty
    property p_dat_hold;
        $changed(DAT_O) |-> ACK_O;
    endproperty
    property p_reset_pins;
        $rose(ARST_N) |-> CH_OE == 0 && CH_PIN_OWN == 0 && CH_PULLUP == 0 && CH_IRQ == 0;
    endproperty
    property p_oe_owned;
        (CH_OE & ~CH_PIN_OWN) == 0;
    endproperty
    property p_pullup_owned;
        (CH_PULLUP & ~CH_PIN_OWN) == 0;
    endproperty
    property p_ext_pin;
        s_ext |-> !CH_PIN_OWN[0] && !CH_OE[0];
    endproperty
    property p_unmapped;
        s_req ##0 (!WE_I && ADR_I == 8'hFC) |=> DAT_O == 0;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack one cycle after request");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved without ack");
    a_reset_pins: assert property (p_reset_pins) else $error("pins active after reset");
    a_oe_owned: assert property (p_oe_owned) else $error("pin driven but not owned");
    a_pullup_owned: assert property (p_pullup_owned) else $error("pullup on free pin");
    a_ext_pin: assert property (p_ext_pin) else $error("channel 0 uses clock pin");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

// [bench/timer_pwm_counter_core_test.sv]
// Self-checking bench for the timer counter core
`timescale 1ns/1ns
module timer_pwm_counter_core_test;
    localparam logic [7:0] hi = timer_pwm_pkg::A_CNT_HIGH;
    localparam logic [7:0] lo = timer_pwm_pkg::A_CNT_LOW;
    localparam logic [7:0] sc = timer_pwm_pkg::A_STATUS_CTRL;
    logic CLK, ARST_N, CYC_I, STB_I, WE_I, ACK_O, FIXED_TICK, pin1, run, ext_pin;
    logic [7:0] ADR_I;
    logic [3:0] SEL_I, half;
    logic [31:0] DAT_I, DAT_O, q;
    logic [15:0] v;
    logic [1:0] CH_OUT, CH_OE, CH_PIN_OWN, CH_PULLUP, CH_IRQ;
    int errors = 0, n_tests = 0, seed = 32'h50FD947B, edges = 0, p, m, n, c;
    timer_pwm_counter_core #(.NCH(2)) timer_pwm_counter_core_i (.CLK(CLK), .ARST_N(ARST_N),
        .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I),
        .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .FIXED_TICK(FIXED_TICK),
        .CH_IN({pin1, ext_pin}), .CH_OUT(CH_OUT), .CH_OE(CH_OE),
        .CH_PIN_OWN(CH_PIN_OWN), .CH_PULLUP(CH_PULLUP), .CH_IRQ(CH_IRQ));
    ext_clock_source ext_clock_source_i (.CLK(CLK), .run(run), .half(half), .pin(ext_pin));
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    always @(posedge CLK) pin1 <= 1'($random(seed));
    always @(posedge ext_pin) edges++;
    function automatic int model(int t, int m, int c);
        if (c != 0) begin
            t = t % (2 * m);
            return t <= m ? t : 2 * m - t;
        end
        return t % ((m == 0 || m == 'hFFFF) ? 65536 : m + 1);
    endfunction
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            $display("CHECK FAILED %s expected %h seen %h", s, x, g);
            errors++;
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge CLK);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I <= w;
        ADR_I <= a;
        DAT_I <= d;
        do begin
            @(posedge CLK);
            t++;
        end while (ACK_O !== 1'b1 && t < 50);
        q = DAT_O;
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        if (t >= 50) errors++;
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge CLK);
    endtask
    task automatic pulse(input int k);
        repeat (k) begin
            @(posedge CLK);
            FIXED_TICK <= 1'b1;
        end
        @(posedge CLK);
        FIXED_TICK <= 1'b0;
        idle(6);
    endtask
    // Gap ticks land between the two byte reads, after the value froze
    task automatic rdcnt(input int hf, input int gap, output logic [15:0] r);
        logic [7:0] b;
        wb(1'b0, hf ? hi : lo, 32'h0);
        b = q[7:0];
        pulse(gap);
        wb(1'b0, hf ? lo : hi, 32'h0);
        r = hf ? {b, q[7:0]} : {q[7:0], b};
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #360000;
        errors++;
        summarize();
    end
    initial begin
        CYC_I = 1'b0;
        STB_I = 1'b0;
        WE_I = 1'b0;
        ADR_I = 8'h00;
        SEL_I = 4'hF;
        DAT_I = 32'h0;
        FIXED_TICK = 1'b0;
        pin1 = 1'b0;
        run = 1'b0;
        half = 4'h2;
        ARST_N = 1'b0;
        repeat (2) @(posedge CLK);
        ARST_N <= 1'b1;
        rdcnt(1, 0, v);
        chk("reset count", 32'h0, {16'h0, v});
        wb(1'b0, sc, 32'h0);
        chk("reset status", 32'h0, q);
        chk("reset pins", 32'h0, {22'h0, CH_IRQ, CH_OUT, CH_OE, CH_PIN_OWN, CH_PULLUP});
        wb(1'b0, 8'hFC, 32'h0);
        chk("unmapped", 32'h0, q);
        for (int i = 0; i < 16; i++) begin
            p = i % 8;
            n = 1 + 32'($unsigned($random(seed)) % 300);
            m = (i % 4 == 0) ? 0 : (i % 4 == 1) ? 'hFFFF : 1 + 32'($unsigned($random(seed)) % 40);
            c = (i % 4 == 3) ? 1 : 0;
            if (i == 15) begin
                p = 0;
                m = 0;
                c = 0;
                n = 65537;
            end
            wb(1'b1, timer_pwm_pkg::A_MOD_HIGH, 32'(m >> 8));
            wb(1'b1, timer_pwm_pkg::A_MOD_LOW, 32'(m & 'hFF));
            wb(1'b1, sc, 32'(c * 32 + 16 + p));
            wb(1'b1, (i % 2) ? hi : lo, $random(seed));
            pulse(n);
            rdcnt(i % 2, 7, v);
            chk("count", 32'(model(n >> p, m, c)), {16'h0, v});
            wb(1'b1, sc, 32'(c * 32 + p));
            pulse(50);
            rdcnt(1 - i % 2, 0, v);
            chk("held", 32'(model((n + 7) >> p, m, c)), {16'h0, v});
            // Left latched on purpose: the next writes must restart it
            wb(1'b0, hi, 32'h0);
        end
        wb(1'b1, sc, 32'h08);
        wb(1'b1, lo, 32'h0);
        idle(40);
        rdcnt(0, 0, v);
        chk("bus clock", 32'h1, {31'h0, v >= 16'd40 && v <= 16'd50});
        // Channel 0 keeps only a pin-less compare: edge select off, irq on
        wb(1'b1, timer_pwm_pkg::A_CH_BASE, 32'h28);
        wb(1'b1, timer_pwm_pkg::A_CH_BASE + timer_pwm_pkg::A_CH_VALUE, 32'h3);
        wb(1'b0, timer_pwm_pkg::A_CH_BASE, 32'h0);
        chk("ch0 armed", 32'h28, q);
        wb(1'b1, sc, 32'h18);
        wb(1'b1, lo, 32'h0);
        edges = 0;
        half <= 4'(2 + $unsigned($random(seed)) % 3);
        run <= 1'b1;
        idle(200);
        run <= 1'b0;
        idle(10);
        rdcnt(1, 0, v);
        chk("ext count", 32'(edges), {16'h0, v});
        wb(1'b0, timer_pwm_pkg::A_CH_BASE, 32'h0);
        chk("ch0 compare flag", 32'h68, q);
        chk("ch0 irq", 32'h1, {31'h0, CH_IRQ[0]});
        summarize();
    end
endmodule
bind timer_pwm_counter_core timer_pwm_counter_core_sva #(.NCH(NCH)) sva_i (.CLK(CLK),
    .ARST_N(ARST_N), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
    .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .CH_OE(CH_OE),
    .CH_PIN_OWN(CH_PIN_OWN), .CH_PULLUP(CH_PULLUP), .CH_IRQ(CH_IRQ));

// [hw/timer_pwm_counter_core.sv]
// Timer/PWM main counter, prescaler, channels and Wishbone register slave
// How it works
// [R01] 16-bit counter with 16-bit modulo limit
// [R02] Modulo zero or all ones runs free
// [R03] Counter reads never disturb counting
// [R04] Any counter byte write resets counter
// [R05] Clock select: none, bus, fixed, external pin
// [R06] External clock synchronised on bus clock
// [R07] External clock below half bus rate
// [R08] Software turns channel 0 edge select off
// [R09] Channel 0 keeps pin-less compare on ext clock
// [R10] Prescale divides by one to 128
// [R11] Centre PWM: up/down count, all channels centre
// [R12] Channels: capture, compare, buffered PWM, pin
// [R13] Each channel has maskable interrupt request
// [R14] Counter bytes read-only, writes only reset
// [R15] Byte read freezes both bytes until other read
// [R16] Latch restarts on reset, counter or control write
// [R17] Reset clears counter to zero
// [R18] After reset timer off, pins input, no pullup
// [R19] Owned pin ignores port data and direction
// [R20] Up count wraps to zero after modulo
// [R21] No clock selected holds counter and prescaler
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/1ns
module timer_pwm_counter_core #(
    parameter int NCH = 2
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [timer_pwm_pkg::ADR_W-1:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [timer_pwm_pkg::DAT_W-1:0] DAT_I,
    output logic [timer_pwm_pkg::DAT_W-1:0] DAT_O,
    output logic ACK_O,
    input wire logic FIXED_TICK,
    input wire logic [NCH-1:0] CH_IN,
    output logic [NCH-1:0] CH_OUT,
    output logic [NCH-1:0] CH_OE,
    output logic [NCH-1:0] CH_PIN_OWN,
    output logic [NCH-1:0] CH_PULLUP,
    output logic [NCH-1:0] CH_IRQ
);
    function automatic logic is_free(input logic [15:0] m);
        is_free = (m == timer_pwm_pkg::MOD_ZERO) || (m == timer_pwm_pkg::MOD_ONES);
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic [6:0] pre_mask(input logic [2:0] code);
        pre_mask = 7'((8'h01 << code) - 8'h01);
    endfunction

    timer_pwm_pkg::status_ctrl_t sc;
    logic [15:0] cnt;
    logic [15:0] modulo_limit;
    timer_pwm_pkg::dir_t dir;
    logic [6:0] pre;
    logic [15:0] hold_buf;
    logic held;
    logic first_high;
    logic [NCH-1:0] s1;
    logic [NCH-1:0] s2;
    logic [NCH-1:0] s3;
    logic [NCH-1:0] lvl;
    timer_pwm_pkg::ch_ctrl_t ch_ctrl [NCH];
    logic [15:0] ch_val [NCH];
    logic [15:0] ch_act [NCH];
    logic [NCH-1:0] cmp_q;

    logic req;
    logic wr;
    logic rd;
    logic a_sc;
    logic a_cnth;
    logic a_cntl;
    logic a_modh;
    logic a_modl;
    logic a_cnt;
    logic [NCH-1:0] a_ctl;
    logic [NCH-1:0] a_val;
    logic [31:0] next_dat;
    logic [NCH-1:0] next_lvl;
    logic [NCH-1:0] rise;
    logic [NCH-1:0] fall;
    logic src;
    logic tick;
    logic ext_mode;
    logic [15:0] top;
    logic [15:0] next_cnt;
    timer_pwm_pkg::dir_t next_dir;
    logic period_end;
    logic [15:0] cnt_view;

    assign req = CYC_I && STB_I && !ACK_O;
    assign wr = req && WE_I;
    assign rd = req && !WE_I;
    assign a_sc = ADR_I == timer_pwm_pkg::A_STATUS_CTRL;
    assign a_cnth = ADR_I == timer_pwm_pkg::A_CNT_HIGH;
    assign a_cntl = ADR_I == timer_pwm_pkg::A_CNT_LOW;
    assign a_modh = ADR_I == timer_pwm_pkg::A_MOD_HIGH;
    assign a_modl = ADR_I == timer_pwm_pkg::A_MOD_LOW;
    assign a_cnt = a_cnth || a_cntl;
    assign ext_mode = sc.clock_source_select == timer_pwm_pkg::CLK_EXT;
    assign cnt_view = held ? hold_buf : cnt;

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            a_ctl[i] = ADR_I == 8'(timer_pwm_pkg::A_CH_BASE + i * timer_pwm_pkg::A_CH_STRIDE);
            a_val[i] = ADR_I == 8'(timer_pwm_pkg::A_CH_BASE + i * timer_pwm_pkg::A_CH_STRIDE
                                   + timer_pwm_pkg::A_CH_VALUE);
        end
    end

    // Pin inputs: three stages, a level counts once stages two and three agree
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            lvl <= '0;
        end else begin
            s1 <= CH_IN; // [R06]
            s2 <= s1;
            s3 <= s2;
            lvl <= next_lvl;
        end
    end

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            next_lvl[i] = (s2[i] == s3[i]) ? s3[i] : lvl[i];
        end
        rise = next_lvl & ~lvl;
        fall = ~next_lvl & lvl;
    end

    // Clock source: one rising edge of the pin gives one count, so the pin
    // must stay well under half the bus rate or edges merge
    always_comb begin
        case (sc.clock_source_select) // [R05]
            timer_pwm_pkg::CLK_BUS: src = 1'b1;
            timer_pwm_pkg::CLK_FIXED: src = FIXED_TICK;
            timer_pwm_pkg::CLK_EXT: src = rise[0]; // [R06]
            default: src = 1'b0; // [R21]
        endcase
        tick = src && ((pre & pre_mask(sc.prescale_select))
                       == pre_mask(sc.prescale_select)); // [R10]
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pre <= timer_pwm_pkg::PRE_RST;
        end else if (wr && a_cnt) begin
            pre <= timer_pwm_pkg::PRE_RST;
        end else if (src) begin
            pre <= 7'(pre + 7'h01); // [R21]
        end
    end

    // Next count value in either counting mode
    always_comb begin
        top = is_free(modulo_limit) ? timer_pwm_pkg::MOD_ONES : modulo_limit; // [R02]
        next_dir = dir;
        if (!sc.center_pwm_select) begin
            next_dir = timer_pwm_pkg::DIR_UP;
            next_cnt = (cnt == top) ? timer_pwm_pkg::CNT_RST
                                    : 16'(cnt + timer_pwm_pkg::CNT_ONE); // [R20]
        end else if (dir == timer_pwm_pkg::DIR_UP) begin
            if (cnt >= top) begin
                next_cnt = 16'(cnt - timer_pwm_pkg::CNT_ONE); // [R11]
                next_dir = (cnt == timer_pwm_pkg::CNT_ONE) ? timer_pwm_pkg::DIR_UP
                                                           : timer_pwm_pkg::DIR_DOWN;
            end else begin
                next_cnt = 16'(cnt + timer_pwm_pkg::CNT_ONE);
            end
        end else begin
            next_cnt = 16'(cnt - timer_pwm_pkg::CNT_ONE);
            if (cnt <= timer_pwm_pkg::CNT_ONE) begin
                next_dir = timer_pwm_pkg::DIR_UP;
            end
        end
        period_end = tick && (next_cnt == timer_pwm_pkg::CNT_RST);
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cnt <= timer_pwm_pkg::CNT_RST; // [R17]
            dir <= timer_pwm_pkg::DIR_UP;
        end else if (wr && a_cnt) begin
            cnt <= timer_pwm_pkg::CNT_RST; // [R04] [R14]
            dir <= timer_pwm_pkg::DIR_UP;
        end else if (tick) begin
            cnt <= next_cnt; // [R01]
            dir <= next_dir;
        end
    end

    // Control and modulo registers
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sc <= timer_pwm_pkg::SC_RST; // [R18]
            modulo_limit <= timer_pwm_pkg::MOD_RST;
        end else if (wr && SEL_I[0]) begin
            if (a_sc) begin
                sc <= timer_pwm_pkg::status_ctrl_t'(DAT_I[5:0]);
            end
            if (a_modh) begin
                modulo_limit[15:8] <= DAT_I[7:0]; // [R01]
            end
            if (a_modl) begin
                modulo_limit[7:0] <= DAT_I[7:0];
            end
        end
    end

    // Read coherency latch: the first byte read freezes both bytes
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            held <= 1'b0; // [R16]
            first_high <= 1'b0;
            hold_buf <= timer_pwm_pkg::CNT_RST;
        end else if (wr && (a_cnt || a_sc)) begin
            held <= 1'b0; // [R16]
        end else if (rd && a_cnt) begin
            if (!held) begin
                held <= 1'b1; // [R15]
                first_high <= a_cnth;
                hold_buf <= cnt; // [R03]
            end else if (a_cnth != first_high) begin
                held <= 1'b0; // [R15]
            end
        end
    end

    // Channels
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        logic pin_ok;
        logic is_pwm;
        logic is_cap;
        logic cap_ev;
        logic match;
        logic pwm_on;
        logic next_out;
        logic next_oe;

        assign pin_ok = (ch_ctrl[g].edge_sel != timer_pwm_pkg::EDGE_OFF)
                        && !(g == 0 && ext_mode); // [R09]
        assign is_pwm = sc.center_pwm_select
                        || (ch_ctrl[g].mode == timer_pwm_pkg::MODE_EDGE_PWM); // [R11] [R12]
        assign is_cap = !is_pwm && (ch_ctrl[g].mode == timer_pwm_pkg::MODE_CAPTURE);
        assign cap_ev = is_cap && pin_ok
                        && ((ch_ctrl[g].edge_sel[0] && rise[g])
                            || (ch_ctrl[g].edge_sel[1] && fall[g]));
        // Compare stays live without a pin, so channel 0 still times in software
        assign match = tick && !is_cap && (cnt == ch_act[g]); // [R09]
        assign pwm_on = cnt < ch_act[g];

        always_comb begin
            next_out = cmp_q[g];
            if (is_pwm) begin
                next_out = ch_ctrl[g].edge_sel[0] ? !pwm_on : pwm_on;
            end
            next_oe = pin_ok && !is_cap; // [R19]
        end

        always_ff @(posedge CLK or negedge ARST_N) begin
            if (!ARST_N) begin
                ch_ctrl[g] <= timer_pwm_pkg::CH_CTRL_RST;
            end else begin
                if (wr && a_ctl[g] && SEL_I[0]) begin
                    ch_ctrl[g] <= timer_pwm_pkg::ch_ctrl_t'(DAT_I[6:0]);
                end
                // Hardware set beats a software clear in the same cycle
                if (cap_ev || match) begin
                    ch_ctrl[g].flag <= 1'b1; // [R13]
                end
            end
        end

        always_ff @(posedge CLK or negedge ARST_N) begin
            if (!ARST_N) begin
                ch_val[g] <= timer_pwm_pkg::VAL_RST;
            end else if (cap_ev) begin
                ch_val[g] <= cnt; // [R12]
            end else if (wr && a_val[g]) begin
                ch_val[g] <= merge16(ch_val[g], DAT_I, SEL_I);
            end
        end

        // PWM duty is buffered to the period end so a cycle never glitches
        always_ff @(posedge CLK or negedge ARST_N) begin
            if (!ARST_N) begin
                ch_act[g] <= timer_pwm_pkg::VAL_RST;
            end else if (!is_pwm || period_end) begin
                ch_act[g] <= ch_val[g]; // [R12]
            end
        end

        always_ff @(posedge CLK or negedge ARST_N) begin
            if (!ARST_N) begin
                cmp_q[g] <= 1'b0;
            end else if (match && !is_pwm) begin
                case (ch_ctrl[g].edge_sel)
                    timer_pwm_pkg::EDGE_RISE: cmp_q[g] <= !cmp_q[g];
                    timer_pwm_pkg::EDGE_FALL: cmp_q[g] <= 1'b0;
                    timer_pwm_pkg::EDGE_BOTH: cmp_q[g] <= 1'b1;
                    default: cmp_q[g] <= cmp_q[g];
                endcase
            end
        end

        always_ff @(posedge CLK or negedge ARST_N) begin
            if (!ARST_N) begin
                CH_OUT[g] <= 1'b0; // [R18]
                CH_OE[g] <= 1'b0;
                CH_PIN_OWN[g] <= 1'b0;
                CH_PULLUP[g] <= 1'b0;
                CH_IRQ[g] <= 1'b0;
            end else begin
                CH_OUT[g] <= next_out;
                CH_OE[g] <= next_oe;
                CH_PIN_OWN[g] <= pin_ok; // [R19]
                CH_PULLUP[g] <= pin_ok && is_cap && ch_ctrl[g].pullup_en;
                CH_IRQ[g] <= ch_ctrl[g].flag && ch_ctrl[g].irq_en; // [R13]
            end
        end
    end

    // Read mux; unmapped addresses read as zero and ignore writes
    always_comb begin
        next_dat = '0;
        if (a_sc) begin
            next_dat[5:0] = sc;
        end else if (a_cnth) begin
            next_dat[7:0] = cnt_view[15:8]; // [R15]
        end else if (a_cntl) begin
            next_dat[7:0] = cnt_view[7:0];
        end else if (a_modh) begin
            next_dat[7:0] = modulo_limit[15:8];
        end else if (a_modl) begin
            next_dat[7:0] = modulo_limit[7:0];
        end
        for (int i = 0; i < NCH; i++) begin
            if (a_ctl[i]) begin
                next_dat[6:0] = ch_ctrl[i];
            end
            if (a_val[i]) begin
                next_dat[15:0] = ch_val[i];
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ACK_O <= 1'b0;
            DAT_O <= '0;
        end else begin
            ACK_O <= req;
            if (rd) begin
                DAT_O <= next_dat;
            end
        end
    end
endmodule

// [hw/timer_pwm_pkg.sv]
// Shared constants and types for the timer/PWM counter core
package timer_pwm_pkg;
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    // Register byte addresses
    localparam logic [7:0] A_STATUS_CTRL = 8'h00;
    localparam logic [7:0] A_CNT_HIGH = 8'h04;
    localparam logic [7:0] A_CNT_LOW = 8'h08;
    localparam logic [7:0] A_MOD_HIGH = 8'h0C;
    localparam logic [7:0] A_MOD_LOW = 8'h10;
    localparam logic [7:0] A_CH_BASE = 8'h20;
    localparam logic [7:0] A_CH_STRIDE = 8'h08;
    localparam logic [7:0] A_CH_VALUE = 8'h04;
    localparam int CH_MAX = 8'h0C;
    // Reset values
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] MOD_RST = 16'h0000;
    localparam logic [15:0] VAL_RST = 16'h0000;
    localparam logic [6:0] PRE_RST = 7'h00;
    // Modulo values that mean free running, and the count step of one
    localparam logic [15:0] MOD_ZERO = 16'h0000;
    localparam logic [15:0] MOD_ONES = 16'hFFFF;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    // Edge/level select codes
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    typedef enum logic [1:0] {
        CLK_NONE = 2'b00,
        CLK_BUS = 2'b01,
        CLK_FIXED = 2'b10,
        CLK_EXT = 2'b11
    } clk_src_t;

    typedef enum logic [1:0] {
        MODE_CAPTURE = 2'b00,
        MODE_COMPARE = 2'b01,
        MODE_EDGE_PWM = 2'b10,
        MODE_SPARE = 2'b11
    } ch_mode_t;

    typedef enum logic {
        DIR_UP = 1'b0,
        DIR_DOWN = 1'b1
    } dir_t;

    // Status/control: bit 5 centre PWM, bits 4:3 clock source, bits 2:0 prescale
    typedef struct packed {
        logic center_pwm_select;
        clk_src_t clock_source_select;
        logic [2:0] prescale_select;
    } status_ctrl_t;

    // Channel control: flag, irq enable, mode, edge select, pullup enable
    typedef struct packed {
        logic flag;
        logic irq_en;
        ch_mode_t mode;
        logic [1:0] edge_sel;
        logic pullup_en;
    } ch_ctrl_t;

    localparam status_ctrl_t SC_RST = '{1'b0, CLK_NONE, 3'h0};
    localparam ch_ctrl_t CH_CTRL_RST = '{1'b0, 1'b0, MODE_CAPTURE, EDGE_OFF, 1'b0};
endpackage
